//--- logic/acrp_defs.vh
/*
  Constants for the converter control register port: register indexes,
  field positions, reset values and timing counts.
  Assumes a 50 MHz master clock; included by bare name.
*/
`ifndef ACRP_DEFS_VH
`define ACRP_DEFS_VH

// Register indexes (seven-bit, read form)
`define ACRP_A_IDENT     7'h00
`define ACRP_A_OUTSW     7'h02
`define ACRP_A_STBY      7'h03
`define ACRP_A_CONV      7'h04
`define ACRP_A_RATE      7'h05
`define ACRP_A_INSEL     7'h07
`define ACRP_A_CHPTR     7'h08
`define ACRP_A_GAIN      7'h17
`define ACRP_A_GPTR      7'h3c
`define ACRP_A_OFSH      7'h3d
`define ACRP_A_OFSM      7'h3e
`define ACRP_A_OFSL      7'h3f
`define ACRP_A_DELAY     7'h42

// Field positions
`define ACRP_B_OUT_OFF   1
`define ACRP_B_SWITCH    0
`define ACRP_B_STBY      0
`define ACRP_B_CAL       2
`define ACRP_B_VARIANT   4

// Conversion command codes
`define ACRP_CMD_STOP    2'h0
`define ACRP_CMD_SINGLE  2'h1
`define ACRP_CMD_CONT    2'h2

// Reset values
`define ACRP_RST_BYTE    8'h00
`define ACRP_RST_CODE    3'h0

// Timing: delay step in us, fixed part in us, clock in MHz
`define ACRP_STEP_US     4000
`define ACRP_FIX_US      100
`define ACRP_MCLK_MHZ    50
`define ACRP_HOLD_CYC    6

`endif

//--- logic/acrp_port.v
/*
  Control register bank and serial port of a multiplexed delta-sigma
  converter. Host shifts a command byte then a data byte (write) or
  reads one byte back. The analog path is modelled by done inputs.
  Assumes serial clock, select and data come from another domain and
  are resynchronised here; serial clock is far slower than i_mclk.
*/
`timescale 1ns/1ps
`include "acrp_defs.vh"

module acrp_port #(
  parameter FOUR_CH = 1,
  parameter [3:0] REVISION = 4'h1, // Arbitrary value
  parameter DELAY_STEP_CYC = `ACRP_STEP_US * `ACRP_MCLK_MHZ
) (
  input wire i_mclk,
  input wire i_rstn,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_serial_in_pin,
  input wire i_cal_done,
  input wire i_conv_done,
  output reg o_serial_out_pin,
  output reg o_serial_out_oe,
  output reg o_low_side_switch,
  output reg o_standby,
  output reg [7:0] o_word_rate,
  output reg [2:0] o_mux_sel,
  output reg [2:0] o_channel_gain,
  output reg o_cal_run,
  output reg o_conv_run,
  output reg o_conv_single,
  output reg o_conv_start
);

  // Fixed part of the start delay, in master clocks
  localparam FIX_CYC = `ACRP_FIX_US * `ACRP_MCLK_MHZ;
  // Frame shape: command bits, then data bits up to a full frame
  localparam [4:0] CMD_BITS = 5'd8;
  localparam [4:0] FRAME_BITS = 5'd16;
  // One-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  // Two-flop synchronisers on the select, clock and data pins
  reg [1:0] cs_s_r, ck_s_r, di_s_r;
  reg ck_d_r;
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      cs_s_r <= 2'h3;
      ck_s_r <= 2'h0;
      di_s_r <= 2'h0;
      ck_d_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[0], i_cs_n};
      ck_s_r <= {ck_s_r[0], i_sclk};
      di_s_r <= {di_s_r[0], i_serial_in_pin};
      ck_d_r <= ck_s_r[1];
    end
  end
  // Edges are read from the second stage only; the first may be
  // metastable and feeds nothing but the second
  wire cs_low = ~cs_s_r[1];
  wire ck_rise = ck_s_r[1] & ~ck_d_r;
  wire ck_fall = ~ck_s_r[1] & ck_d_r;

  // Stored registers
  reg [1:0] outsw_r;
  reg stby_r;
  reg [2:0] conv_r;
  reg [7:0] rate_r, delay_r;
  reg [2:0] insel_r, chptr_r, gptr_r;
  // Per-channel gains and per-gain offsets are flops indexed by pointer
  reg [2:0] gain_r [0:7];
  reg [7:0] ofs_h_r [0:7];
  reg [7:0] ofs_m_r [0:7];
  reg [7:0] ofs_l_r [0:7];

  // True when a select code names the supply or temperature input
  function is_monitor;
    input [2:0] code;
    begin
      // Codes above the monitor pair are unused and keep the stored gain
      if (FOUR_CH != 0)
        is_monitor = (code == 3'h4) || (code == 3'h5);
      else
        is_monitor = (code == 3'h2) || (code == 3'h3);
    end
  endfunction

  // True once the command byte of a read frame is in; the shifter and
  // the output enable both use it, so they cannot disagree
  function rd_phase;
    input [7:0] cmd;
    input [4:0] cnt;
    begin
      rd_phase = !cmd[7] && (cnt >= CMD_BITS);
    end
  endfunction

  // True when the command field of the conversion byte holds a code
  function cmd_is;
    input [2:0] conv;
    input [1:0] code;
    begin
      cmd_is = (conv[1:0] == code);
    end
  endfunction

  // Read mux; seven-bit index shared with writes
  // Unmapped indexes read as zero
  function [7:0] rd_val;
    input [6:0] a;
    begin
      case (a)
        `ACRP_A_IDENT: rd_val = {3'h0, (FOUR_CH == 0), REVISION};
        `ACRP_A_OUTSW: rd_val = {6'h00, outsw_r};
        `ACRP_A_STBY: rd_val = {7'h00, stby_r};
        `ACRP_A_CONV: rd_val = {5'h00, conv_r};
        `ACRP_A_RATE: rd_val = rate_r;
        `ACRP_A_INSEL: rd_val = {5'h00, insel_r};
        `ACRP_A_CHPTR: rd_val = {5'h00, chptr_r};
        `ACRP_A_GAIN: rd_val = {5'h00, gain_r[chptr_r]};
        `ACRP_A_GPTR: rd_val = {5'h00, gptr_r};
        `ACRP_A_OFSH: rd_val = ofs_h_r[gptr_r];
        `ACRP_A_OFSM: rd_val = ofs_m_r[gptr_r];
        `ACRP_A_OFSL: rd_val = ofs_l_r[gptr_r];
        `ACRP_A_DELAY: rd_val = delay_r;
        default: rd_val = 8'h00;
      endcase
    end
  endfunction

  // Serial shifter: bit count, command and data bytes
  // Count stops at a full frame, so a long frame cannot wrap it
  reg [4:0] bit_cnt_r;
  reg [7:0] cmd_r, dat_r, rd_sh_r;
  reg wr_pend_r;
  reg sdo_r;
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      bit_cnt_r <= 5'h00;
      cmd_r <= 8'h00;
      dat_r <= 8'h00;
      rd_sh_r <= 8'h00;
      wr_pend_r <= 1'b0;
      sdo_r <= 1'b0;
    end else if (!cs_low) begin
      // Select high ends the frame; a full write is queued to commit
      wr_pend_r <= (bit_cnt_r == FRAME_BITS) && cmd_r[7];
      bit_cnt_r <= 5'h00;
      sdo_r <= 1'b0;
    end else begin
      wr_pend_r <= 1'b0;
      // Extra clocks past a full frame are ignored
      if (ck_rise && bit_cnt_r != FRAME_BITS) begin
        bit_cnt_r <= bit_cnt_r + 5'd1;
        if (bit_cnt_r < CMD_BITS)
          cmd_r <= {cmd_r[6:0], di_s_r[1]};
        else
          dat_r <= {dat_r[6:0], di_s_r[1]};
        if (bit_cnt_r == CMD_BITS - 5'd1)
          rd_sh_r <= rd_val({cmd_r[5:0], di_s_r[1]});
      end
      // Read data changes on falling edges, MSB first
      if (ck_fall && rd_phase(cmd_r, bit_cnt_r) &&
          bit_cnt_r < FRAME_BITS) begin
        sdo_r <= rd_sh_r[7];
        rd_sh_r <= {rd_sh_r[6:0], 1'b0};
      end
    end
  end

  // Commit strobe and its index; the strobe comes only from a full
  // write frame, so an old command is never applied again
  wire wr_go = wr_pend_r;
  wire [6:0] wa = cmd_r[6:0];
  // Loop index for the array resets
  integer k;

  // Register writes on the master clock and hardware clears
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      outsw_r <= 2'h0;
      stby_r <= 1'b0;
      conv_r <= 3'h0;
      rate_r <= `ACRP_RST_BYTE;
      delay_r <= `ACRP_RST_BYTE;
      insel_r <= `ACRP_RST_CODE;
      chptr_r <= `ACRP_RST_CODE;
      gptr_r <= `ACRP_RST_CODE;
      for (k = 0; k < 8; k = k + 1) begin
        gain_r[k] <= `ACRP_RST_CODE;
        ofs_h_r[k] <= `ACRP_RST_BYTE;
        ofs_m_r[k] <= `ACRP_RST_BYTE;
        ofs_l_r[k] <= `ACRP_RST_BYTE;
      end
    end else begin
      // Hardware completion first; a same-cycle write then overrides
      // Calibration runs before any conversion, so its clear goes first
      if (i_cal_done && conv_r[`ACRP_B_CAL])
        conv_r[`ACRP_B_CAL] <= 1'b0;
      else if (i_conv_done && cmd_is(conv_r, `ACRP_CMD_SINGLE))
        conv_r[1:0] <= `ACRP_CMD_STOP;
      // Standby drops the switch as well; a switch write in the same
      // cycle lands for one cycle and is cleared on the next
      if (stby_r)
        outsw_r[`ACRP_B_SWITCH] <= 1'b0;
      if (wr_go) begin
        case (wa)
          `ACRP_A_OUTSW: outsw_r <= dat_r[1:0];
          `ACRP_A_STBY: stby_r <= dat_r[`ACRP_B_STBY];
          `ACRP_A_CONV: conv_r <= dat_r[2:0];
          `ACRP_A_RATE: rate_r <= dat_r;
          `ACRP_A_INSEL: insel_r <= dat_r[2:0];
          `ACRP_A_CHPTR: chptr_r <= dat_r[2:0];
          `ACRP_A_GAIN: gain_r[chptr_r] <= dat_r[2:0];
          `ACRP_A_GPTR: gptr_r <= dat_r[2:0];
          `ACRP_A_OFSH: ofs_h_r[gptr_r] <= dat_r;
          `ACRP_A_OFSM: ofs_m_r[gptr_r] <= dat_r;
          `ACRP_A_OFSL: ofs_l_r[gptr_r] <= dat_r;
          `ACRP_A_DELAY: delay_r <= dat_r;
          default: ;
        endcase
      end
    end
  end

  // Start-delay sequencer: waits delay*4ms+100us then pulses start
  reg [2:0] st_r;
  reg [7:0] step_r;
  reg [31:0] tick_r;
  reg [2:0] last_sel_r;
  // A conversion is wanted for single or continuous code, never while
  // calibrating or in standby; code 11 is unused and starts nothing
  wire want = (cmd_is(conv_r, `ACRP_CMD_SINGLE) ||
               cmd_is(conv_r, `ACRP_CMD_CONT)) &&
              !conv_r[`ACRP_B_CAL] && !stby_r;
  // Delay expiry: fixed part and all steps used up
  wire start_due = (st_r == ST_WAIT) && want && (tick_r <= 32'h1) &&
                   (step_r == 8'h00);
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_r <= ST_IDLE;
      step_r <= 8'h00;
      tick_r <= 32'h0;
      last_sel_r <= 3'h0;
    end else begin
      last_sel_r <= insel_r;
      case (st_r)
        ST_IDLE: begin
          // Load the fixed part first; the steps follow it
          if (want) begin
            st_r <= ST_WAIT;
            step_r <= delay_r;
            tick_r <= FIX_CYC;
          end
        end
        ST_WAIT: begin
          // Dropping the request abandons the wait without a start
          if (!want)
            st_r <= ST_IDLE;
          else if (tick_r > 32'h1)
            tick_r <= tick_r - 32'h1;
          // Each step reloads the counter; a 4 ms step needs 18 bits
          else if (step_r != 8'h00) begin
            step_r <= step_r - 8'h01;
            tick_r <= DELAY_STEP_CYC;
          end else
            st_r <= ST_RUN;
        end
        ST_RUN: begin
          // Mux change in continuous mode reinserts the delay
          if (!want || i_conv_done ||
              (last_sel_r != insel_r))
            st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Registered outputs; every pin comes from a flop so decode glitches
  // never reach the analog side
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_serial_out_pin <= 1'b0;
      o_serial_out_oe <= 1'b0;
      o_low_side_switch <= 1'b0;
      o_standby <= 1'b0;
      o_word_rate <= 8'h00;
      o_mux_sel <= 3'h0;
      o_channel_gain <= 3'h0;
      o_cal_run <= 1'b0;
      o_conv_run <= 1'b0;
      o_conv_single <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      o_serial_out_pin <= sdo_r;
      // Drive only during read data phase and when not floated
      o_serial_out_oe <= ~outsw_r[`ACRP_B_OUT_OFF] & cs_low &
                         rd_phase(cmd_r, bit_cnt_r);
      o_low_side_switch <= outsw_r[`ACRP_B_SWITCH];
      o_standby <= stby_r;
      o_word_rate <= rate_r;
      o_mux_sel <= insel_r;
      // Monitor inputs bypass the amplifier whatever gain is stored
      o_channel_gain <= is_monitor(insel_r) ? 3'h0 :
                    gain_r[insel_r];
      o_cal_run <= conv_r[`ACRP_B_CAL] & ~stby_r;
      o_conv_run <= (st_r == ST_RUN);
      o_conv_single <= cmd_is(conv_r, `ACRP_CMD_SINGLE);
      o_conv_start <= start_due;
    end
  end

endmodule

//--- test/acrp_port_sva.sv
/* Assertions on the register port pins.
   Bound into every acrp_port; one clock domain only. */
`timescale 1ns/1ps
module acrp_port_sva #(
  parameter FOUR_CH = 1
) (
  input wire i_mclk,
  input wire i_rstn,
  input wire i_cs_n,
  input wire i_cal_done,
  input wire i_conv_done,
  input wire o_serial_out_oe,
  input wire o_low_side_switch,
  input wire o_standby,
  input wire [7:0] o_word_rate,
  input wire [2:0] o_mux_sel,
  input wire [2:0] o_channel_gain,
  input wire o_cal_run,
  input wire o_conv_single,
  input wire o_conv_start
);
  // Monitor codes depend on the variant
  wire mon_sel = (FOUR_CH != 0) ? (o_mux_sel == 3'h4 || o_mux_sel == 3'h5)
                                : (o_mux_sel == 3'h2 || o_mux_sel == 3'h3);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // Done pulses end the mode they belong to
  sequence s_cal_end; i_cal_done && o_cal_run; endsequence
  sequence s_one_end; i_conv_done && o_conv_single; endsequence
  property p_cal_clr; s_cal_end |-> ##[1:3] !o_cal_run; endproperty
  a_cal_clr: assert property (p_cal_clr) else $error("cal kept");
  property p_one_clr; s_one_end |-> ##[1:3] !o_conv_single; endproperty
  a_one_clr: assert property (p_one_clr) else $error("one kept");
  property p_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  // Settled states get one cycle of slack, outputs are registered
  property p_cal_pri;
    o_cal_run && $past(o_cal_run) |-> !o_conv_start;
  endproperty
  a_cal_pri: assert property (p_cal_pri) else $error("start in cal");
  property p_stby;
    o_standby && $past(o_standby) |-> !o_low_side_switch;
  endproperty
  a_stby: assert property (p_stby) else $error("switch on");
  property p_mon;
    mon_sel |-> o_channel_gain == 3'h0;
  endproperty
  a_mon: assert property (p_mon) else $error("gain not 1x");
  // A commit must wait for select to have risen
  property p_commit;
    $changed(o_word_rate) |-> i_cs_n && $past(i_cs_n, 3);
  endproperty
  a_commit: assert property (p_commit) else $error("early commit");
  property p_oe; $rose(o_serial_out_oe) |-> !i_cs_n; endproperty
  a_oe: assert property (p_oe) else $error("oe unselected");
endmodule

bind acrp_port acrp_port_sva #(.FOUR_CH(FOUR_CH)) acrp_port_sva_i (.i_mclk,
  .i_rstn, .i_cs_n,
  .i_cal_done, .i_conv_done, .o_serial_out_oe, .o_low_side_switch,
  .o_standby, .o_word_rate, .o_mux_sel, .o_channel_gain, .o_cal_run,
  .o_conv_single, .o_conv_start);

//--- test/acrp_host.sv
/* Host side of the serial control port.
   Called by the bench; paces itself on the master clock. */
`timescale 1ns/1ps
module acrp_host (
  input wire i_mclk,
  input wire i_sdo,
  input wire i_oe,
  output reg o_cs_n,
  output reg o_sclk,
  output reg o_sdi
);
  reg oe_seen = 1'b0;
  // Idle: deselected, clock parked low
  initial {o_cs_n, o_sclk, o_sdi} = 3'b100;
  // One frame of nb clocks, command then data, MSB first
  task xfer(input [7:0] c, input [7:0] d, input integer nb, output [7:0] r);
    integer k;
    reg [15:0] w;
    begin
      w = {c, d};
      r = 8'h00;
      oe_seen = 1'b0;
      @(posedge i_mclk);
      #1 o_cs_n = 1'b0;
      o_sdi = w[15];
      repeat (4) @(posedge i_mclk);
      for (k = 0; k < nb; k = k + 1) begin
        repeat (4) @(posedge i_mclk);
        #1 o_sclk = 1'b1;
        repeat (4) @(posedge i_mclk);
        #1 oe_seen = oe_seen | i_oe;
        // Undriven output reads inverted so it cannot pass as data
        if (k > 7) r = {r[6:0], i_oe ? i_sdo : ~i_sdo};
        o_sclk = 1'b0;
        o_sdi = (k < 15) ? w[14 - k] : ~o_sdi;
      end
      repeat (4) @(posedge i_mclk);
      #1 o_cs_n = 1'b1;
      o_sdi = ~o_sdi;
      repeat (12) @(posedge i_mclk);
      #1;
    end
  endtask
endmodule

//--- test/test_acrp_port.sv
/* Bench for the converter register port.
   Host model owns the pins; done pulses come from here. */
`timescale 1ns/1ps
module test_acrp_port;
  reg i_mclk = 1'b0;
  reg i_rstn = 1'b0;
  reg i_cal_done = 1'b0;
  reg i_conv_done = 1'b0;
  wire i_cs_n, i_sclk, i_serial_in_pin, o_serial_out_pin, o_serial_out_oe;
  wire o_low_side_switch, o_standby, o_cal_run, o_conv_run, o_conv_single;
  wire o_conv_start;
  wire [7:0] o_word_rate;
  wire [2:0] o_mux_sel, o_channel_gain;
  integer fails = 0, cmp_count = 0, seed = 32'h3ce3, i, n;
  reg [7:0] r, v;
  // 50 MHz master clock
  always #10 i_mclk = ~i_mclk;
  // Short delay step keeps the start timer small; revision arbitrary
  acrp_port #(.REVISION(4'h6), .DELAY_STEP_CYC(20)) acrp_port_i (.i_mclk,
    .i_rstn, .i_cs_n, .i_sclk, .i_serial_in_pin, .i_cal_done, .i_conv_done,
    .o_serial_out_pin, .o_serial_out_oe, .o_low_side_switch, .o_standby,
    .o_word_rate, .o_mux_sel, .o_channel_gain, .o_cal_run, .o_conv_run,
    .o_conv_single, .o_conv_start);
  acrp_host acrp_host_i (.i_mclk, .i_sdo(o_serial_out_pin),
    .i_oe(o_serial_out_oe), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_sdi(i_serial_in_pin));
  // Expected values: monitor inputs run at 1x
  function [7:0] f_gain(input [2:0] c, input [2:0] g);
    f_gain = c[2] ? 8'h00 : {5'h0, g};
  endfunction
  function integer f_wait(input [7:0] d);
    f_wait = 5000 + d * 20; // 100 us plus d steps
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    acrp_host_i.xfer({1'b1, a}, d, 16, r);
  endtask
  task rd(input [6:0] a, input [7:0] e);
    begin
      acrp_host_i.xfer({1'b0, a}, 8'h00, 16, r);
      chk(r, e);
    end
  endtask
  task finish_test;
    begin
      if (fails == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(7'h00, 8'h06);
    for (i = 2; i < 6; i = i + 1) rd(i[6:0], 8'h00);
    rd(7'h7f, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      wr(7'h05, v);
      chk(o_word_rate, v);
      rd(7'h05, v);
    end
    acrp_host_i.xfer(8'h85, ~v, 12, r);
    rd(7'h05, v);
    wr(7'h02, 8'h01);
    rd(7'h02, 8'h01);
    chk({o_low_side_switch, acrp_host_i.oe_seen}, 8'h03);
    wr(7'h02, 8'h03);
    acrp_host_i.xfer(8'h00, 8'h00, 16, r);
    chk(acrp_host_i.oe_seen, 8'h00);
    wr(7'h03, 8'h01);
    chk({o_standby, o_low_side_switch}, 8'h02);
    wr(7'h03, 8'h00);
    wr(7'h02, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      v = $random(seed);
      wr(7'h08, i[7:0]);
      wr(7'h17, v & 8'h07);
      wr(7'h07, i[7:0]);
      chk(o_mux_sel, i[7:0]);
      chk(o_channel_gain, f_gain(i[2:0], v[2:0]));
    end
    for (i = 3; i < 6; i = i + 2) begin
      wr(7'h3c, i[7:0]);
      wr(7'h3d, 8'ha0 + i[7:0]);
      wr(7'h3f, 8'h50 + i[7:0]);
      wr(7'h3e, 8'hc0 + i[7:0]);
    end
    wr(7'h3c, 8'h03);
    rd(7'h3d, 8'ha3);
    rd(7'h3f, 8'h53);
    rd(7'h3e, 8'hc3);
    // Reset in mid-run returns the bank to its defaults
    @(posedge i_mclk) #1 i_rstn = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_mclk);
    rd(7'h05, 8'h00);
    rd(7'h3d, 8'h00);
    wr(7'h42, 8'h02);
    wr(7'h04, 8'h01);
    for (n = 0; n < 6000 && o_conv_start !== 1'b1; n = n + 1)
      @(posedge i_mclk) #1;
    fails = fails + (n == 6000);
    if (n == 6000) finish_test;
    chk(n + 16 >= f_wait(8'h02) && n <= f_wait(8'h02), 8'h01);
    chk(o_conv_single, 8'h01);
    @(posedge i_mclk) #1 chk(o_conv_run, 8'h01);
    i_conv_done = 1'b1;
    @(posedge i_mclk) #1 i_conv_done = 1'b0;
    rd(7'h04, 8'h00);
    wr(7'h04, 8'h06);
    chk(o_cal_run, 8'h01);
    i_cal_done = 1'b1;
    @(posedge i_mclk) #1 i_cal_done = 1'b0;
    rd(7'h04, 8'h02);
    finish_test;
  end
endmodule
